/* rtl/aam_top.v */
// Purpose: Auxiliary converter control: start bits, thresholds,
//          result capture, events and PLL lost-lock flag.
// Assumes: Core special function register port, one-cycle strobes.
// Notes:   Result registers are written only by converter events.
// Notes on behaviour
// [R1] Voltage delta: 000 off, 001-110 LSB change, 111 every result.
// [R2] Writing one to start bit 7 clears the PLL lost-lock flag.
// [R3] A PLL lost-lock reset sets the PLL lost-lock flag.
// [R4] Start bit 2 requests voltage conversion, self-clears on acceptance.
// [R5] Start bit 1 requests temperature conversion, self-clears on acceptance.
// [R6] Start bit 0 requests battery conversion, self-clears on acceptance.
// [R7] Battery result below low-battery threshold raises an event.
// [R8] Result registers load only when their converter event occurs.
// [R9] Temperature 8-bit result goes to the register at 0xd7.
// [R10] Single temperature conversion raises event when result is readable.
// [R11] Temperature conversions start by software or periodic background.
// [R12] Background result interrupts when change from last exceeds delta.
// [R13] Temperature delta codes work like the voltage delta codes.
// [R14] Battery interval: 00 off, 01 16 min, 10 4 min, 11 1 min.
// [R15] Start bits are independent; each request held until accepted.
// [R16] Each event is a one-cycle pulse with its result load.
`timescale 1ns/10ps
`include "aam_regs.vh"
module aam_top #(
   parameter [31:0] CYCLES_PER_MIN = `AAM_CYCLES_PER_MIN
) (
   input  wire       i_clock,
   input  wire       i_nrst,
   input  wire [7:0] i_sfr_addr,
   input  wire [7:0] i_sfr_wdata,
   input  wire       i_sfr_wr,
   input  wire       i_pll_lost_lock_reset,
   input  wire [2:0] i_conv_accept,
   input  wire [2:0] i_conv_done,
   input  wire [7:0] i_batt_data,
   input  wire [7:0] i_temp_data,
   input  wire [7:0] i_extv_data,
   output reg  [7:0] o_sfr_rdata,
   output wire [2:0] o_conv_req,
   output wire [2:0] o_conv_event,
   output reg        o_pll_lost_lock_flag
);

   reg        rst_meta_reg;
   reg        rst_sync_reg;
   reg  [7:0] delta_threshold_reg;
   reg  [7:0] strobe_period_reg;
   reg  [7:0] low_battery_threshold_reg;
   reg  [7:0] peripheral_config_register_rest_reg;
   reg  [31:0] minute_cnt_reg;
   reg  [3:0] minute_num_reg;
   reg        minute_tick_reg;
   wire [2:0] go_bits;
   wire [2:0] set_go;
   wire [2:0] bg_req;
   wire [7:0] result [0:2];
   wire [2:0] delta [0:2];
   wire [1:0] ivl [0:2];
   wire       wr_start;
   wire       wr_delta;
   wire       wr_strobe;
   wire       wr_low_batt;
   wire       wr_peripheral_config_register;
   wire [7:0] ch_data [0:2];
   reg  [7:0] rdata_next;

   function is_wr;
      input [7:0] addr;
      input [7:0] target;
      input       wr;
      begin
         is_wr = wr & (addr == target);
      end
   endfunction

   // Interval field to period in minutes; battery uses the longer table
   function due;
      input [1:0] code;
      input       long;
      input [3:0] mins;
      begin
         case (code)
            2'b01:   due = long ? (mins == 4'd15) : (mins[2:0] == 3'd7);
            2'b10:   due = long ? (mins[1:0] == 2'd3) : (mins[0] == 1'b1);
            2'b11:   due = 1'b1;
            default: due = 1'b0;
         endcase
      end
   endfunction

   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign wr_start    = is_wr(i_sfr_addr, `AAM_ADDR_CONV_START, i_sfr_wr);
   assign wr_delta    = is_wr(i_sfr_addr, `AAM_ADDR_DELTA_THR, i_sfr_wr);
   assign wr_strobe   = is_wr(i_sfr_addr, `AAM_ADDR_STROBE_PER, i_sfr_wr);
   assign wr_low_batt = is_wr(i_sfr_addr, `AAM_ADDR_LOW_BATT_THR, i_sfr_wr);
   assign wr_peripheral_config_register   = is_wr(i_sfr_addr, `AAM_ADDR_PERIPHERAL_CONFIG_REGISTER_CFG, i_sfr_wr);

   // [R5] Temperature start is bit 1
   // [R6] Battery start is bit 0
   // Bit 7 is a pure strobe; it never lands in a channel
   assign set_go = {3{wr_start}} & i_sfr_wdata[2:0];

   // Channel index order: battery, temperature, voltage
   assign ch_data[0] = i_batt_data;
   assign ch_data[1] = i_temp_data;
   assign ch_data[2] = i_extv_data;

   always @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         delta_threshold_reg       <= `AAM_RESET_BYTE;
         strobe_period_reg         <= `AAM_RESET_BYTE;
         low_battery_threshold_reg <= `AAM_RESET_BYTE;
         peripheral_config_register_rest_reg           <= `AAM_RESET_BYTE;
         o_pll_lost_lock_flag      <= 1'b0;
         o_sfr_rdata               <= `AAM_RESET_BYTE;
      end else begin
         // Reserved bits dropped on write so they always read zero
         if (wr_delta)
            delta_threshold_reg <= i_sfr_wdata & 8'h3f;
         if (wr_strobe)
            strobe_period_reg <= i_sfr_wdata & 8'h3f;
         if (wr_low_batt)
            low_battery_threshold_reg <= i_sfr_wdata;
         // Flag position is owned by hardware, never by software
         if (wr_peripheral_config_register)
            peripheral_config_register_rest_reg <= i_sfr_wdata & 8'hef;
         // [R3] Lost-lock reset sets flag; set beats clear
         // [R2] Acknowledge bit clears flag
         if (i_pll_lost_lock_reset)
            o_pll_lost_lock_flag <= 1'b1;
         else if (wr_start & i_sfr_wdata[`AAM_GO_PLL_ACK_BIT])
            o_pll_lost_lock_flag <= 1'b0;
         o_sfr_rdata <= rdata_next;
      end
   end

   // [R14] Minute base for background intervals
   // Free running, so the first run after a period write may come
   // early; later runs keep the full spacing
   always @(posedge i_clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         minute_cnt_reg  <= 32'h0;
         minute_num_reg  <= 4'h0;
         minute_tick_reg <= 1'b0;
      end else begin
         minute_tick_reg <= 1'b0;
         if (minute_cnt_reg == CYCLES_PER_MIN - 32'h1) begin
            minute_cnt_reg  <= 32'h0;
            minute_num_reg  <= minute_num_reg + 4'h1;
            minute_tick_reg <= 1'b1;
         end else begin
            minute_cnt_reg <= minute_cnt_reg + 32'h1;
         end
      end
   end

   // Read data registered one cycle after the address
   always @* begin
      case (i_sfr_addr)
         `AAM_ADDR_TEMP_RESULT:  rdata_next = result[1];
         `AAM_ADDR_CONV_START:   rdata_next = {5'h00, go_bits};
         `AAM_ADDR_BATT_RESULT:  rdata_next = result[0];
         `AAM_ADDR_EXTV_RESULT:  rdata_next = result[2];
         `AAM_ADDR_DELTA_THR:    rdata_next = delta_threshold_reg;
         `AAM_ADDR_PERIPHERAL_CONFIG_REGISTER_CFG:
            rdata_next = peripheral_config_register_rest_reg |
                         {3'h0, o_pll_lost_lock_flag, 4'h0};
         `AAM_ADDR_STROBE_PER:   rdata_next = strobe_period_reg;
         `AAM_ADDR_LOW_BATT_THR: rdata_next = low_battery_threshold_reg;
         default:                rdata_next = `AAM_RESET_BYTE;
      endcase
   end

   // [R1] Voltage delta field
   assign delta[2] = delta_threshold_reg[2:0];
   // [R13] Temperature delta field
   assign delta[1] = delta_threshold_reg[5:3];
   assign delta[0] = `AAM_DELTA_OFF;
   assign ivl[0] = strobe_period_reg[3:2];
   assign ivl[1] = strobe_period_reg[1:0];
   assign ivl[2] = strobe_period_reg[5:4];

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ch
         // [R11] Background due on interval
         assign bg_req[g] = minute_tick_reg &
                            due(ivl[g], g == 0, minute_num_reg);
         // [R9] Temperature result capture
         // [R10] Event with readable result
         aam_channel #(
            .IS_BATT(g == 0)
         ) u_ch (
            .i_clock     (i_clock),
            .i_rst_n     (rst_sync_reg),
            .i_set_go    (set_go[g]),
            .i_bg_req    (bg_req[g]),
            .i_accept    (i_conv_accept[g]),
            .i_done      (i_conv_done[g]),
            .i_data      (ch_data[g]),
            .i_delta     (delta[g]),
            .i_threshold (low_battery_threshold_reg),
            .o_go        (go_bits[g]),
            .o_req       (o_conv_req[g]),
            .o_event     (o_conv_event[g]),
            .o_result    (result[g])
         );
      end
   endgenerate

endmodule // aam_top

/* rtl/aam_regs.vh */
// Purpose: Register map, field positions and timing counts for the
//          auxiliary measurement control block.
// Assumes: 8-bit special function register port from the core.
// Notes:   Definitions only.
`ifndef AAM_REGS_VH
`define AAM_REGS_VH

`define AAM_ADDR_TEMP_RESULT  8'hd7
`define AAM_ADDR_CONV_START   8'hd8
`define AAM_ADDR_BATT_RESULT  8'hdf
`define AAM_ADDR_EXTV_RESULT  8'hef
`define AAM_ADDR_DELTA_THR    8'hf3
`define AAM_ADDR_PERIPHERAL_CONFIG_REGISTER_CFG   8'hf4
`define AAM_ADDR_STROBE_PER   8'hf9
`define AAM_ADDR_LOW_BATT_THR 8'hfa

`define AAM_GO_BATT_BIT       0
`define AAM_GO_TEMP_BIT       1
`define AAM_GO_EXTV_BIT       2
`define AAM_GO_PLL_ACK_BIT    7
`define AAM_PLL_FLAG_BIT      4

`define AAM_EXTV_DELTA_LSB    0
`define AAM_TEMP_DELTA_LSB    3
`define AAM_TEMP_IVL_LSB      0
`define AAM_BATT_IVL_LSB      2
`define AAM_EXTV_IVL_LSB      4

`define AAM_DELTA_OFF         3'h0
`define AAM_DELTA_EVERY       3'h7
`define AAM_RESET_BYTE        8'h00

`define AAM_CLOCK_HZ          32'd50000000
`define AAM_MIN_1             1
`define AAM_MIN_2             2
`define AAM_MIN_4             4
`define AAM_MIN_8             8
`define AAM_MIN_16            16
`define AAM_SECONDS_PER_MIN   32'd60
// Cycles in one minute at the system clock
`define AAM_CYCLES_PER_MIN    (`AAM_CLOCK_HZ * `AAM_SECONDS_PER_MIN)

`endif

/* rtl/aam_channel.v */
// Purpose: One converter channel: request hold, result capture, event.
// Assumes: Converter strobes are synchronous to i_clock.
// Notes:   Shared by battery, temperature and external voltage.
`timescale 1ns/10ps
`include "aam_regs.vh"
module aam_channel #(
   parameter IS_BATT = 0
) (
   input  wire       i_clock,
   input  wire       i_rst_n,
   input  wire       i_set_go,
   input  wire       i_bg_req,
   input  wire       i_accept,
   input  wire       i_done,
   input  wire [7:0] i_data,
   input  wire [2:0] i_delta,
   input  wire [7:0] i_threshold,
   output reg        o_go,
   output reg        o_req,
   output reg        o_event,
   output reg  [7:0] o_result
);

   reg        single_reg;
   reg        bg_pend_reg;
   reg  [7:0] last_reg;
   wire [7:0] diff;
   wire       fire;

   assign diff = (i_data > last_reg) ? (i_data - last_reg)
                                     : (last_reg - i_data);
   // Single shots always fire; background ones per mode
   // [R7] Battery below threshold
   // [R12] Change beyond delta
   assign fire = i_done & (single_reg |
                 (IS_BATT ? (i_data < i_threshold) :
                  (i_delta == `AAM_DELTA_EVERY) ? 1'b1 :
                  (i_delta == `AAM_DELTA_OFF)   ? 1'b0 :
                  (diff > {5'h00, i_delta})));

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_go        <= 1'b0;
         o_req       <= 1'b0;
         bg_pend_reg <= 1'b0;
         single_reg  <= 1'b0;
         o_event     <= 1'b0;
         o_result    <= `AAM_RESET_BYTE;
         last_reg    <= `AAM_RESET_BYTE;
      end else begin
         // [R4] Go held until accept
         // [R15] Independent hold per channel
         if (i_set_go)
            o_go <= 1'b1;
         else if (i_accept & o_go)
            o_go <= 1'b0;
         // [R11] Background start path
         if (i_bg_req)
            bg_pend_reg <= 1'b1;
         else if (i_accept & ~o_go)
            bg_pend_reg <= 1'b0;
         o_req <= (o_go | i_set_go | bg_pend_reg | i_bg_req) & ~i_accept;
         if (i_accept)
            single_reg <= o_go;
         // [R8] Result loads only with the event
         // [R16] Event pulse with the load
         o_event <= fire;
         if (fire) begin
            o_result <= i_data;
            last_reg <= i_data;
         end
      end
   end

endmodule // aam_channel

/* tb/aam_conv_model.sv */
// Purpose: Stand-in for the three converters.
// Assumes: Requests are levels held until accepted.
// Notes:   Data is valid only with done; inverted at other times.
`timescale 1ns/10ps
module aam_conv_model (
   input  wire        i_clock,
   input  wire [2:0]  i_req,
   input  wire [23:0] i_val,
   output wire [2:0]  o_accept,
   output wire [2:0]  o_done,
   output wire [23:0] o_data
);
   for (genvar k = 0; k < 3; k++) begin : g_ch
      logic       acc = 1'b0;
      logic       dn = 1'b0;
      logic [2:0] cnt = 3'h0;
      assign o_accept[k] = acc;
      assign o_done[k] = dn;
      assign o_data[8*k+:8] = dn ? i_val[8*k+:8] : ~i_val[8*k+:8];
      // Each channel converts at its own speed
      always @(posedge i_clock) begin
         acc <= 1'b0;
         dn <= cnt == 3'h1;
         if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
         else if (i_req[k] && !acc) begin
            acc <= 1'b1;
            cnt <= 3'h2 + 3'(k);
         end
      end
   end
endmodule // aam_conv_model

/* tb/aam_top_asserts.sv */
// Purpose: Port-level checks of the converter control block.
// Assumes: One clock; checks idle while reset is low.
// Notes:   Bound to every aam_top instance.
`timescale 1ns/10ps
module aam_top_asserts #(
   parameter CYCLES_PER_MIN = 20
) (
   input wire       i_clock,
   input wire       i_nrst,
   input wire [7:0] i_sfr_addr,
   input wire [7:0] i_sfr_wdata,
   input wire       i_sfr_wr,
   input wire       i_pll_lost_lock_reset,
   input wire [2:0] i_conv_accept,
   input wire [2:0] i_conv_done,
   input wire [7:0] i_temp_data,
   input wire [7:0] o_sfr_rdata,
   input wire [2:0] o_conv_req,
   input wire [2:0] o_conv_event,
   input wire       o_pll_lost_lock_flag
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);
   wire go_wr = i_sfr_wr && i_sfr_addr == 8'hd8;

   a_req_on_write: assert property (
      go_wr |=> (o_conv_req & $past(i_sfr_wdata[2:0])) == $past(i_sfr_wdata[2:0]))
      else $error("start write gave no request");
   a_req_held: assert property (
      o_conv_req[1] && !i_conv_accept[1] |=> o_conv_req[1])
      else $error("request dropped early");
   a_req_drop: assert property (
      o_conv_req[2] && i_conv_accept[2] && !go_wr |=> !o_conv_req[2])
      else $error("request kept after accept");
   a_event_pulse: assert property (
      |o_conv_event |=> (o_conv_event & $past(o_conv_event)) == 3'h0)
      else $error("event longer than one cycle");
   a_event_cause: assert property (
      |o_conv_event |-> (o_conv_event & ~$past(i_conv_done)) == 3'h0)
      else $error("event without done");
   a_temp_readable: assert property (
      o_conv_event[1] && i_sfr_addr == 8'hd7
      |=> o_sfr_rdata == $past(i_temp_data, 2))
      else $error("temperature not readable with event");
   a_pll_set: assert property (
      i_pll_lost_lock_reset |=> o_pll_lost_lock_flag)
      else $error("lost-lock flag not set");
   a_pll_clear: assert property (
      go_wr && i_sfr_wdata[7] && !i_pll_lost_lock_reset
      |=> !o_pll_lost_lock_flag)
      else $error("lost-lock flag not cleared");

   c_start: cover property (go_wr ##1 o_conv_req != 3'h0);
   c_batt: cover property (o_conv_event[0]);
   c_pll: cover property (o_pll_lost_lock_flag ##1 !o_pll_lost_lock_flag);
endmodule // aam_top_asserts

bind aam_top aam_top_asserts #(.CYCLES_PER_MIN(CYCLES_PER_MIN)) u_chk (
   .i_clock(i_clock), .i_nrst(i_nrst), .i_sfr_addr(i_sfr_addr),
   .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
   .i_pll_lost_lock_reset(i_pll_lost_lock_reset),
   .i_conv_accept(i_conv_accept), .i_conv_done(i_conv_done),
   .i_temp_data(i_temp_data), .o_sfr_rdata(o_sfr_rdata),
   .o_conv_req(o_conv_req), .o_conv_event(o_conv_event),
   .o_pll_lost_lock_flag(o_pll_lost_lock_flag));

/* tb/aam_top_bench.sv */
// Purpose: Self-checking run of the converter control block.
// Assumes: Converter model answers every request.
// Notes:   A minute is shortened to 20 cycles.
`timescale 1ns/10ps
module aam_top_bench;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        wr = 1'b0;
   logic        pll = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [23:0] val = 24'h000000;
   wire  [23:0] cdata;
   wire  [7:0]  rdata;
   wire  [2:0]  req, ev, acc, dn;
   wire         flag;
   int          evn [3] = '{0, 0, 0};
   int          err_total = 0;
   int          num_checks = 0;

   aam_top #(.CYCLES_PER_MIN(20)) dut (
      .i_clock(clk), .i_nrst(nrst), .i_sfr_addr(addr),
      .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_pll_lost_lock_reset(pll),
      .i_conv_accept(acc), .i_conv_done(dn), .i_batt_data(cdata[7:0]),
      .i_temp_data(cdata[15:8]), .i_extv_data(cdata[23:16]),
      .o_sfr_rdata(rdata), .o_conv_req(req), .o_conv_event(ev),
      .o_pll_lost_lock_flag(flag));
   aam_conv_model model (.i_clock(clk), .i_req(req), .i_val(val),
      .o_accept(acc), .o_done(dn), .o_data(cdata));

   initial begin
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      for (int k = 0; k < 3; k++)
         evn[k] += ev[k];
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic get(string what, logic [7:0] a, logic [7:0] exp);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      check(what, exp, rdata);
   endtask
   // Waits for an exact event count; a long wait ends the run
   task automatic wait_n(int k, int n);
      int t;
      t = 0;
      while (evn[k] < n && t < 60) begin
         @(negedge clk);
         t++;
      end
      check("event count", n[15:0], evn[k][15:0]);
      if (evn[k] < n)
         report_and_stop();
   endtask
   // Cycles from one event of a channel to its next; a long wait ends the run
   task automatic gap(int k, int exp);
      int t;
      t = 0;
      for (int r = 0; r < 2; r++) begin
         t = 0;
         do begin
            @(negedge clk);
            t++;
         end while (!ev[k] && t < 700);
      end
      check("event gap", exp[15:0], t[15:0]);
      if (t >= 700)
         report_and_stop();
   endtask

   task automatic t_single();
      val = 24'h3c5aa5;
      put(8'hd8, 8'h07);
      check("requests", 8'h07, {5'h0, req});
      addr = 8'hd7;
      wait_n(0, 1);
      wait_n(1, 1);
      wait_n(2, 1);
      get("start bits", 8'hd8, 8'h00);
      get("temperature", 8'hd7, 8'h5a);
      get("battery", 8'hdf, 8'ha5);
      get("voltage", 8'hef, 8'h3c);
      put(8'hd7, 8'h11);
      get("temperature kept", 8'hd7, 8'h5a);
      $display("single conversions done");
   endtask
   task automatic t_pll();
      @(negedge clk);
      pll = 1'b1;
      @(negedge clk);
      pll = 1'b0;
      @(negedge clk);
      check("lost-lock flag", 8'h01, {7'h0, flag});
      get("peripheral", 8'hf4, 8'h10);
      put(8'hd8, 8'h80);
      check("lost-lock flag", 8'h00, {7'h0, flag});
      // Lost-lock event and acknowledge in the same cycle
      @(negedge clk);
      addr = 8'hd8;
      wdata = 8'h80;
      wr = 1'b1;
      pll = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      pll = 1'b0;
      check("set over clear", 8'h01, {7'h0, flag});
      put(8'hd8, 8'h80);
      get("peripheral", 8'hf4, 8'h00);
      $display("lost-lock flag done");
   endtask
   task automatic t_regs();
      put(8'hf3, 8'hff);
      get("delta register", 8'hf3, 8'h3f);
      put(8'hf9, 8'hc0);
      get("period register", 8'hf9, 8'h00);
      put(8'hf4, 8'hff);
      get("peripheral", 8'hf4, 8'hef);
      put(8'hf4, 8'h00);
      put(8'hf3, 8'h00);
      $display("register masks done");
   endtask
   task automatic t_batt();
      int b;
      put(8'hfa, 8'h40);
      val = 24'h000030;
      b = evn[0];
      put(8'hf9, 8'h0c);
      wait_n(0, b + 1);
      get("battery", 8'hdf, 8'h30);
      val = 24'h000040;
      b = evn[0];
      repeat (60) @(negedge clk);
      wait_n(0, b);
      get("battery kept", 8'hdf, 8'h30);
      put(8'hf9, 8'h00);
      $display("battery threshold done");
   endtask
   task automatic t_delta();
      int b;
      put(8'hf3, 8'h07);
      val = 24'h500000;
      b = evn[2];
      put(8'hf9, 8'h30);
      wait_n(2, b + 1);
      put(8'hf3, 8'h02);
      val = 24'h520000;
      b = evn[2];
      repeat (60) @(negedge clk);
      wait_n(2, b);
      val = 24'h530000;
      wait_n(2, b + 1);
      put(8'hf3, 8'h00);
      val = 24'h100000;
      b = evn[2];
      repeat (60) @(negedge clk);
      wait_n(2, b);
      put(8'hf9, 8'h00);
      $display("voltage delta done");
   endtask
   task automatic t_temp();
      int b;
      put(8'hf3, 8'h38);
      val = 24'h005a00;
      b = evn[1];
      put(8'hf9, 8'h03);
      wait_n(1, b + 1);
      put(8'hf3, 8'h08);
      val = 24'h005b00;
      repeat (60) @(negedge clk);
      wait_n(1, b + 1);
      val = 24'h005c00;
      wait_n(1, b + 2);
      get("temperature", 8'hd7, 8'h5c);
      put(8'hf9, 8'h00);
      $display("temperature delta done");
   endtask
   task automatic t_period();
      val = 24'h000030;
      put(8'hf3, 8'h3f);
      put(8'hf9, 8'h04);
      gap(0, 320);
      put(8'hf9, 8'h08);
      gap(0, 80);
      put(8'hf9, 8'h0c);
      gap(0, 20);
      put(8'hf9, 8'h02);
      gap(1, 40);
      put(8'hf9, 8'h10);
      gap(2, 160);
      put(8'hf9, 8'h00);
      $display("background periods done");
   endtask

   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      get("threshold", 8'hfa, 8'h00);
      get("temperature", 8'hd7, 8'h00);
      t_single();
      t_pll();
      t_regs();
      t_batt();
      t_delta();
      t_temp();
      t_period();
      report_and_stop();
   end
endmodule // aam_top_bench
